// ===== common/ps_cfg_pkg.sv
// Package: constants, states and carrier types for the passive serial loader
package ps_cfg_pkg;

  // Core clock
  localparam int unsigned CORE_CLK_PERIOD_PS = 5000;

  // Power-on-reset delay, least figures in microseconds
  localparam int unsigned POR_FAST_MIN_US = 4000;
  localparam int unsigned POR_STD_MIN_US  = 100000;
  localparam int unsigned POR_FAST_CYC    = (POR_FAST_MIN_US * 1000 + CORE_CLK_PERIOD_PS / 1000 - 1)
                                            / (CORE_CLK_PERIOD_PS / 1000) ;
  localparam int unsigned POR_STD_CYC     = (POR_STD_MIN_US * 1000 + CORE_CLK_PERIOD_PS / 1000 - 1)
                                            / (CORE_CLK_PERIOD_PS / 1000);

  // Done-to-user-mode window with internal oscillator, microseconds
  localparam int unsigned DONE2UM_MIN_US = 175;
  localparam int unsigned DONE2UM_MAX_US = 437;
  localparam int unsigned DONE2UM_CYC    = (DONE2UM_MIN_US * 1000 + CORE_CLK_PERIOD_PS / 1000 - 1)
                                           / (CORE_CLK_PERIOD_PS / 1000);

  // User init clock: enable after 4 max serial clock periods, then 8576 periods
  localparam int unsigned SER_CLK_MAX_PERIOD_NS = 48;
  localparam int unsigned UCLK_EN_PERIODS       = 4;
  localparam int unsigned UCLK_EN_CYC           = (UCLK_EN_PERIODS * SER_CLK_MAX_PERIOD_NS * 1000
                                                  + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;
  localparam int unsigned UCLK_INIT_EDGES       = 8576;

  // Extra falling edges needed after done
  localparam logic [1:0] EXTRA_FALL_EDGES = 2'h2;

  // Pin-to-edge latency of the link synchronisers, core cycles
  localparam int unsigned SYNC_LAT_CYC = 4;

  // Image layout: option bits sit in the first word
  localparam int unsigned WORD_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned IMAGE_BITS    = 1024;
  localparam int unsigned OPT_INIT_DONE = 0;
  localparam int unsigned OPT_USER_CLK  = 1;
  localparam int unsigned OPT_DATA_IO   = 2;

  // Configuration sequence
  typedef enum logic [2:0] {
    ST_POR    = 3'h0,
    ST_RESET  = 3'h1,
    ST_LOAD   = 3'h3,
    ST_DONE   = 3'h2,
    ST_INIT   = 3'h6,
    ST_USER   = 3'h7,
    ST_ERROR  = 3'h5
  } cfg_state_t;

  // Open-drain or two-way pin carrier
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  // Option bits caught from the image
  typedef struct packed {
    logic data_io;
    logic user_clk;
    logic init_done;
  } cfg_opts_t;

endpackage

// ===== logic/word_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic             load;

  // Count covers storage and output stage, so full means DEPTH words held
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  // Refill output stage when empty or taken; a word just written waits a cycle
  assign load       = (count != (AW+1)'(out_valid_o)) && (!out_valid_o || out_ready_i);

  // Storage writes
  always_ff @(posedge clk_i)
  begin
    if (ce_i && push)
      mem[wr_idx] <= in_data_i;
  end

  // Pointers and count
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else if (ce_i)
    begin
      if (flush_i)
      begin
        wr_idx <= '0;
        rd_idx <= '0;
        count  <= '0;
      end
      else
      begin
        if (push)
          wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + AW'(1);
        if (load)
          rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + AW'(1);
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  // Registered output stage, so the drain side leaves straight from flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else if (ce_i)
    begin
      if (flush_i)
        out_valid_o <= 1'b0;
      else if (load)
      begin
        out_valid_o <= 1'b1;
        out_data_o  <= mem[rd_idx];
      end
      else if (pop)
        out_valid_o <= 1'b0;
    end
  end
endmodule

// ===== logic/ps_cfg_loader.sv
// Passive serial configuration sequencer of the device
`timescale 1ns/1ps
module ps_cfg_loader
  import ps_cfg_pkg::*;
#(
  parameter int unsigned POR_FAST_CYCLES = POR_FAST_CYC,
  parameter int unsigned POR_STD_CYCLES  = POR_STD_CYC,
  parameter int unsigned DONE2UM_CYCLES  = DONE2UM_CYC,
  parameter int unsigned UCLK_EDGES      = UCLK_INIT_EDGES,
  parameter int unsigned IMAGE_LEN_BITS  = IMAGE_BITS
) (
  // Clock, reset, enable
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic              ce_i,
  // Strap: power-on delay select, high for fast
  input  wire logic              por_fast_i,
  // Configuration pins
  input  wire logic              config_request_n_i,
  input  wire logic              cfg_status_n_i,
  output logic                   cfg_status_n_o,
  output logic                   cfg_status_n_oe_o,
  input  wire logic              cfg_done_i,
  output logic                   cfg_done_o,
  output logic                   cfg_done_oe_o,
  input  wire logic              cfg_serial_clk_i,
  input  wire logic              cfg_serial_data_i,
  input  wire logic              user_init_clk_i,
  // Init-done pin
  output logic                   init_done_o,
  output logic                   init_done_oe_o,
  // User-mode data pin path
  input  wire logic              user_data_o_i,
  input  wire logic              user_data_oe_i,
  output logic                   cfg_serial_data_o,
  output logic                   cfg_serial_data_oe_o,
  // Core side: image words and state
  output logic                   cfg_word_valid_o,
  input  wire logic              cfg_word_ready_i,
  output logic [WORD_W-1:0]      cfg_word_o,
  input  wire logic              cfg_crc_err_i,
  output logic                   user_mode_o
);
  localparam int unsigned CW = 32;

  // Three-stage synchroniser: second and third must agree
  function automatic logic agreed(input logic [2:0] s, input logic held);
    agreed = (s[1] == s[2]) ? s[2] : held;
  endfunction

  logic       rst_m;
  logic       rst_n;
  logic [2:0] s_req, s_sclk, s_sdat, s_uclk;
  logic       req_n, sclk, sdat, uclk, sclk_q, uclk_q;
  logic       sclk_rise, sclk_fall, uclk_rise;
  cfg_state_t state, next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] bit_cnt;
  logic [WORD_W-1:0] shreg;
  logic [WORD_W-1:0] word_hold;
  logic [2:0] bit_in_word;
  logic       word_valid;
  logic       word_ready;
  logic [1:0] fall_cnt;
  logic       uclk_en;
  cfg_opts_t  opts;
  logic       opt_loaded;
  logic       err;
  logic       por_fast;

  // Reset release through two flops
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Pin synchronisers; stage 0 read only by stage 1
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_req  <= 3'h7;
      s_sclk <= 3'h0;
      s_sdat <= 3'h0;
      s_uclk <= 3'h0;
      req_n  <= 1'b1;
      sclk   <= 1'b0;
      sdat   <= 1'b0;
      uclk   <= 1'b0;
      sclk_q <= 1'b0;
      uclk_q <= 1'b0;
    end
    else if (ce_i)
    begin
      s_req  <= {s_req[1:0], config_request_n_i};
      s_sclk <= {s_sclk[1:0], cfg_serial_clk_i};
      s_sdat <= {s_sdat[1:0], cfg_serial_data_i};
      s_uclk <= {s_uclk[1:0], user_init_clk_i};
      req_n  <= agreed(s_req, req_n);
      sclk   <= agreed(s_sclk, sclk);
      sdat   <= agreed(s_sdat, sdat);
      uclk   <= agreed(s_uclk, uclk);
      sclk_q <= sclk;
      uclk_q <= uclk;
    end
  end

  assign sclk_rise = sclk & ~sclk_q;
  assign sclk_fall = ~sclk & sclk_q;
  assign uclk_rise = uclk & ~uclk_q;

  // Power-on delay strap caught after reset release
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      por_fast <= 1'b0;
    else if (ce_i && state == ST_POR && cnt == '0)
      por_fast <= por_fast_i;
  end

  // Sequence control
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_POR:
        if (cnt >= CW'(por_fast ? POR_FAST_CYCLES : POR_STD_CYCLES))
          next_state = req_n ? ST_LOAD : ST_RESET;
      ST_RESET:
        if (req_n)
          next_state = ST_LOAD;
      ST_LOAD:
        if (!req_n)
          next_state = ST_RESET;
        else if (err)
          next_state = ST_ERROR;
        else if (bit_cnt == CW'(IMAGE_LEN_BITS) && !word_valid)
          next_state = ST_DONE;
      ST_DONE:
        if (!req_n)
          next_state = ST_RESET;
        else if (fall_cnt == EXTRA_FALL_EDGES)
          next_state = ST_INIT;
      ST_INIT:
        if (!req_n)
          next_state = ST_RESET;
        // One edge more than periods, so the last user clock period is whole
        else if (opts.user_clk ? (uclk_en && cnt > CW'(UCLK_EDGES))
                               : (cnt >= CW'(DONE2UM_CYCLES)))
          next_state = ST_USER;
      ST_USER, ST_ERROR:
        if (!req_n)
          next_state = ST_RESET;
      default:
        next_state = ST_POR;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_POR;
    else if (ce_i)
      state <= next_state;
  end

  // Cycle counter; in init with user clock it times the enable delay, then counts edges
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (ce_i)
    begin
      if (next_state != state)
        cnt <= '0;
      else if (state == ST_INIT && opts.user_clk && !uclk_en)
        cnt <= (cnt >= CW'(UCLK_EN_CYC)) ? '0 : cnt + CW'(1);
      else if (state == ST_INIT && opts.user_clk)
        cnt <= uclk_rise ? cnt + CW'(1) : cnt;
      else
        cnt <= cnt + CW'(1);
    end
  end

  // User clock enable after four max serial clock periods
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      uclk_en <= 1'b0;
    else if (ce_i)
    begin
      if (state != ST_INIT)
        uclk_en <= 1'b0;
      else if (cnt >= CW'(UCLK_EN_CYC))
        uclk_en <= 1'b1;
    end
  end

  // Extra falling edges after done; a fall still in the synchroniser belongs to the last bit
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      fall_cnt <= '0;
    else if (ce_i)
    begin
      if (state != ST_DONE)
        fall_cnt <= '0;
      else if (sclk_fall && fall_cnt != EXTRA_FALL_EDGES && cnt >= CW'(SYNC_LAT_CYC))
        fall_cnt <= fall_cnt + 2'h1;
    end
  end

  // Serial shift: one bit per rising edge, packed MSB first
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shreg       <= '0;
      word_hold   <= '0;
      bit_in_word <= '0;
      bit_cnt     <= '0;
      word_valid  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state != ST_LOAD)
      begin
        bit_in_word <= '0;
        bit_cnt     <= '0;
        word_valid  <= 1'b0;
      end
      else
      begin
        if (word_valid && word_ready)
          word_valid <= 1'b0;
        // Bits past the image length are ignored
        if (sclk_rise && bit_cnt != CW'(IMAGE_LEN_BITS))
        begin
          shreg       <= {shreg[WORD_W-2:0], sdat};
          bit_in_word <= bit_in_word + 3'h1;
          bit_cnt     <= bit_cnt + CW'(1);
          // Completed word kept apart, so a stalled push never sees the next bits
          if (bit_in_word == 3'h7)
          begin
            word_valid <= 1'b1;
            word_hold  <= {shreg[WORD_W-2:0], sdat};
          end
        end
      end
    end
  end

  // Overrun or core CRC report marks the load failed
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      err <= 1'b0;
    else if (ce_i)
    begin
      if (state == ST_RESET)
        err <= 1'b0;
      else if (state == ST_LOAD && (cfg_crc_err_i || (word_valid && !word_ready && sclk_rise
               && bit_in_word == 3'h7)))
        err <= 1'b1;
    end
  end

  // Option bits live in the first image word
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opts       <= '0;
      opt_loaded <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state == ST_RESET)
      begin
        opts       <= '0;
        opt_loaded <= 1'b0;
      end
      else if (state == ST_LOAD && word_valid && !opt_loaded && bit_cnt <= CW'(2 * WORD_W))
      begin
        opts       <= {word_hold[OPT_DATA_IO], word_hold[OPT_USER_CLK], word_hold[OPT_INIT_DONE]};
        opt_loaded <= 1'b1;
      end
    end
  end

  // Buffer between serial link and core; full stalls into the error path
  word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .ce_i        (ce_i),
    .flush_i     (state == ST_RESET),
    .in_valid_i  (word_valid),
    .in_ready_o  (word_ready),
    .in_data_i   (word_hold),
    .out_valid_o (cfg_word_valid_o),
    .out_ready_i (cfg_word_ready_i),
    .out_data_o  (cfg_word_o)
  );

  // Pin drives, all registered
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_status_n_o       <= 1'b0;
      cfg_status_n_oe_o    <= 1'b1;
      cfg_done_o           <= 1'b0;
      cfg_done_oe_o        <= 1'b1;
      init_done_o          <= 1'b0;
      init_done_oe_o       <= 1'b0;
      cfg_serial_data_o    <= 1'b0;
      cfg_serial_data_oe_o <= 1'b0;
      user_mode_o          <= 1'b0;
    end
    else if (ce_i)
    begin
      cfg_status_n_o       <= 1'b0;
      cfg_status_n_oe_o    <= (next_state == ST_POR || next_state == ST_RESET
                               || next_state == ST_ERROR);
      cfg_done_o           <= 1'b0;
      cfg_done_oe_o        <= (next_state == ST_POR || next_state == ST_RESET
                               || next_state == ST_LOAD || next_state == ST_ERROR);
      init_done_o          <= 1'b0;
      init_done_oe_o       <= opts.init_done && opt_loaded && next_state != ST_USER
                              && next_state != ST_RESET;
      cfg_serial_data_o    <= user_data_o_i;
      cfg_serial_data_oe_o <= (next_state == ST_USER) && opts.data_io && user_data_oe_i;
      user_mode_o          <= (next_state == ST_USER);
    end
  end

  // Checks
  int unsigned lo_cnt;
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      lo_cnt <= 0;
    else if (ce_i)
      lo_cnt <= (state == ST_INIT) ? lo_cnt + 1 : 0;
  end

  property p_status_por;
    @(posedge core_clk_i) disable iff (!rst_n) (state == ST_POR) |-> cfg_status_n_oe_o;
  endproperty
  a_status_por: assert property (p_status_por) else $error("status released in POR");

  property p_done_low_load;
    @(posedge core_clk_i) disable iff (!rst_n) (state == ST_LOAD && next_state == ST_LOAD) |=> cfg_done_oe_o;
  endproperty
  a_done_low_load: assert property (p_done_low_load) else $error("done released while loading");

  property p_done_full;
    @(posedge core_clk_i) disable iff (!rst_n)
      (state == ST_LOAD && next_state == ST_DONE) |-> (bit_cnt == CW'(IMAGE_LEN_BITS)) && !err;
  endproperty
  a_done_full: assert property (p_done_full) else $error("done before full image");

  property p_two_falls;
    @(posedge core_clk_i) disable iff (!rst_n)
      (state == ST_DONE && next_state == ST_INIT) |-> fall_cnt == 2'h2;
  endproperty
  a_two_falls: assert property (p_two_falls) else $error("init without two falls");

  property p_req_restart;
    @(posedge core_clk_i) disable iff (!rst_n)
      (ce_i && !req_n && state == ST_USER) |=> state == ST_RESET;
  endproperty
  a_req_restart: assert property (p_req_restart) else $error("request ignored");

  property p_um_min;
    @(posedge core_clk_i) disable iff (!rst_n)
      (state == ST_INIT && next_state == ST_USER && !opts.user_clk) |-> lo_cnt >= DONE2UM_CYCLES;
  endproperty
  a_um_min: assert property (p_um_min) else $error("user mode too early");

  property p_uclk_en;
    @(posedge core_clk_i) disable iff (!rst_n) $rose(uclk_en) |-> lo_cnt > UCLK_EN_CYC;
  endproperty
  a_uclk_en: assert property (p_uclk_en) else $error("user clock enabled early");

  property p_um_uclk;
    @(posedge core_clk_i) disable iff (!rst_n)
      (state == ST_INIT && next_state == ST_USER && opts.user_clk) |-> uclk_en && cnt > CW'(UCLK_EDGES);
  endproperty
  a_um_uclk: assert property (p_um_uclk) else $error("user clock count short");

  property p_data_io;
    @(posedge core_clk_i) disable iff (!rst_n) cfg_serial_data_oe_o |-> user_mode_o;
  endproperty
  a_data_io: assert property (p_data_io) else $error("data pin driven outside user mode");

  property p_init_pin;
    @(posedge core_clk_i) disable iff (!rst_n) init_done_oe_o |-> !init_done_o && $past(opt_loaded);
  endproperty
  a_init_pin: assert property (p_init_pin) else $error("init pin before option");

  c_load_done: cover property (@(posedge core_clk_i) disable iff (!rst_n) state == ST_LOAD ##1 state == ST_DONE);
  c_user: cover property (@(posedge core_clk_i) disable iff (!rst_n) state == ST_INIT ##1 state == ST_USER);
  c_reconf: cover property (@(posedge core_clk_i) disable iff (!rst_n) state == ST_USER ##1 state == ST_RESET);
  c_error: cover property (@(posedge core_clk_i) disable iff (!rst_n) state == ST_LOAD ##1 state == ST_ERROR);
endmodule

// ===== test/ps_cfg_host.sv
// Partner model: external configuration host driving the serial link
`timescale 1ns/1ps
module ps_cfg_host (
  // Link pins
  output logic cfg_serial_clk_o,
  output logic cfg_serial_data_o,
  output logic config_request_n_o
);
  // Clock parked low between frames, request idle high
  initial
  begin
    cfg_serial_clk_o   = 1'b0;
    cfg_serial_data_o  = 1'b0;
    config_request_n_o = 1'b1;
  end

  // Request pulse starts a new reconfiguration
  task automatic reconfigure();
    #0.7;
    config_request_n_o = 1'b0;
    #103;
    config_request_n_o = 1'b1;
  endtask

  // MSB first, data set on the fall, device samples on the rise
  task automatic send(input logic [7:0] w, input int nbits);
    #0.7;
    for (int i = 7; i >= 8 - nbits; i--)
    begin
      cfg_serial_data_o = w[i];
      #24 cfg_serial_clk_o = 1'b1;
      #24 cfg_serial_clk_o = 1'b0;
    end
    // Stale data must not look valid once the bit is used
    cfg_serial_data_o = ~cfg_serial_data_o;
  endtask

  // Two falling edges after done, then clock parked low
  task automatic finish_edges();
    #0.7;
    repeat (2)
    begin
      #24 cfg_serial_clk_o = 1'b1;
      #24 cfg_serial_clk_o = 1'b0;
    end
  endtask
endmodule

// ===== test/ps_cfg_loader_tb.sv
// Self-checking bench for the passive serial configuration loader
`timescale 1ns/1ps
module ps_cfg_loader_tb
  import ps_cfg_pkg::*;
;
  localparam int POR_F = 50;
  localparam int POR_S = 100;
  localparam int D2U   = 40;
  localparam int UE    = 16;
  localparam int IMG   = 512;
  localparam int NW    = IMG / 8;

  logic              core_clk, arst_n, por_fast, uclk, udo, udoe, ready, crc_err, stall, crc_req, ce;
  logic              req_n, sclk, sdata, st_o, st_oe, dn_o, dn_oe, ini_o, ini_oe;
  logic              sd_o, sd_oe, wvalid, umode, st_w, dn_w;
  logic [WORD_W-1:0] word;
  logic [7:0]        rx[$];
  int                num_errors, comparisons, cyc;

  // Open-drain lines with pull-ups
  assign st_w = st_oe ? st_o : 1'b1;
  assign dn_w = dn_oe ? dn_o : 1'b1;

  ps_cfg_host host_i (.cfg_serial_clk_o(sclk), .cfg_serial_data_o(sdata), .config_request_n_o(req_n));

  ps_cfg_loader #(.POR_FAST_CYCLES(POR_F), .POR_STD_CYCLES(POR_S), .DONE2UM_CYCLES(D2U),
                  .UCLK_EDGES(UE), .IMAGE_LEN_BITS(IMG)) ps_cfg_loader_i (
    .core_clk_i(core_clk), .arst_n_i(arst_n), .ce_i(ce), .por_fast_i(por_fast),
    .config_request_n_i(req_n), .cfg_status_n_i(st_w), .cfg_status_n_o(st_o),
    .cfg_status_n_oe_o(st_oe), .cfg_done_i(dn_w), .cfg_done_o(dn_o), .cfg_done_oe_o(dn_oe),
    .cfg_serial_clk_i(sclk), .cfg_serial_data_i(sdata), .user_init_clk_i(uclk),
    .init_done_o(ini_o), .init_done_oe_o(ini_oe), .user_data_o_i(udo), .user_data_oe_i(udoe),
    .cfg_serial_data_o(sd_o), .cfg_serial_data_oe_o(sd_oe), .cfg_word_valid_o(wvalid),
    .cfg_word_ready_i(ready), .cfg_word_o(word), .cfg_crc_err_i(crc_err), .user_mode_o(umode));

  // Core clock and unrelated user init clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    uclk = 1'b0;
    #1.1;
    forever #20 uclk = ~uclk;
  end

  // Core-side inputs launched just after the edge; words caught on handshake
  always @(posedge core_clk)
  begin
    ready <= #1 ~stall;
    crc_err <= #1 crc_req;
    if (wvalid === 1'b1 && ready === 1'b1)
      rx.push_back(word);
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      final_report();
    end
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h..%0h", $time, got, lo, hi);
    end
  endtask

  function automatic logic [7:0] exp_word(input logic [7:0] opts, input int w);
    return (w == 0) ? opts : 8'h3C ^ 8'(w);
  endfunction

  task automatic final_report();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset(input logic fast);
    int n;
    arst_n = 1'b0;
    por_fast = fast;
    repeat (5) tick();
    arst_n = 1'b1;
    for (n = 0; n < 2000 && st_oe !== 1'b0; n++) tick();
    check_cnt(n, fast ? POR_F : POR_S, (fast ? POR_F : POR_S) + 6);
    check_bit(dn_w, 1'b0);
  endtask

  // Reconfigure, then shift nbits with optional stall and error word
  task automatic send_image(input logic [7:0] opts, input int nbits, input int stall_w, input int crc_w);
    int n;
    rx.delete();
    host_i.reconfigure();
    check_bit(st_w, 1'b0);
    for (n = 0; n < 2000 && st_w !== 1'b1; n++) tick();
    for (int w = 0; w * 8 < nbits; w++)
    begin
      tick();
      stall = (w < stall_w);
      crc_req = (w == crc_w);
      if (w == 32) check_bit(dn_w, 1'b0);
      host_i.send(exp_word(opts, w), (nbits - w * 8 > 8) ? 8 : nbits - w * 8);
    end
    tick();
    stall = 1'b0;
    crc_req = 1'b0;
  endtask

  task automatic t_good(input logic [7:0] opts);
    int n, m, lo, hi;
    send_image(opts, IMG, 20, -1);
    for (n = 0; n < 300 && dn_w !== 1'b1; n++) tick();
    check_cnt(n, 0, 20);
    check_bit(ini_oe, opts[0]);
    check_bit(ini_o, 1'b0);
    check_bit(umode, 1'b0);
    fork
      host_i.finish_edges();
    join_none
    for (m = 0; m < 1000 && umode !== 1'b1; m++) tick();
    lo = opts[1] ? int'(UCLK_EN_CYC) + UE * 8 : D2U;
    hi = opts[1] ? lo + 400 : D2U * 437 / 175;
    check_cnt(m, lo, hi);
    check_bit(st_w & dn_w, 1'b1);
    check_cnt(rx.size(), NW, NW);
    foreach (rx[i]) check_word(rx[i], exp_word(opts, i));
    udo = 1'b1;
    udoe = 1'b1;
    repeat (4) tick();
    check_bit(sd_oe, opts[2]);
    check_bit(sd_o, 1'b1);
    udoe = 1'b0;
  endtask

  task automatic t_partial();
    send_image(8'h00, IMG - 8, 0, -1);
    repeat (200) tick();
    check_bit(dn_w, 1'b0);
    check_bit(umode, 1'b0);
    // Frozen by the clock enable, a request pulse goes unseen
    ce = 1'b0;
    host_i.reconfigure();
    repeat (4) tick();
    check_bit(st_w, 1'b1);
    ce = 1'b1;
  endtask

  task automatic t_crc();
    send_image(8'h00, IMG, 0, 10);
    repeat (20) tick();
    check_bit(st_w, 1'b0);
    check_bit(dn_w, 1'b0);
  endtask

  // Far side stalls throughout, so the buffer overruns, then drains
  task automatic t_overrun();
    send_image(8'h00, IMG, NW, -1);
    check_bit(st_w, 1'b0);
    check_bit(dn_w, 1'b0);
    repeat (60) tick();
    check_bit(wvalid, 1'b0);
    check_cnt(rx.size(), FIFO_DEPTH, FIFO_DEPTH);
  endtask

  initial
  begin
    arst_n = 1'b0;
    por_fast = 1'b1;
    udo = 1'b0;
    udoe = 1'b0;
    ready = 1'b0;
    crc_err = 1'b0;
    stall = 1'b1;
    crc_req = 1'b0;
    ce = 1'b1;
    num_errors = 0;
    comparisons = 0;
    cyc = 0;
    do_reset(1'b1);
    t_good(8'h01);
    t_good(8'h06);
    t_partial();
    t_crc();
    t_overrun();
    do_reset(1'b0);
    final_report();
  end
endmodule
